// >>> src/ttc_regs.vh
`ifndef TTC_REGS_VH
`define TTC_REGS_VH
// Count clock select codes
`define TTC_SEL_EXT 3'h7
`define TTC_SEL_DIV_MAX 3'h6
`define TTC_PRE_ALL 7'h7F
// Output action codes
`define TTC_OUT_KEEP 2'h0
`define TTC_OUT_LOW 2'h1
`define TTC_OUT_HIGH 2'h2
`define TTC_OUT_TGL 2'h3
// Capture edge codes
`define TTC_EDGE_OFF 2'h0
`define TTC_EDGE_RISE 2'h1
`define TTC_EDGE_FALL 2'h2
`define TTC_EDGE_BOTH 2'h3
// Reset values
`define TTC_CNT_RST 16'h0000
`define TTC_CNT_MAX 16'hFFFF
`define TTC_PRE_RST 7'h00
`define TTC_SEL_RST 3'h0
`endif

// >>> src/ttc_timer.v
`timescale 1ns/1ps
`include "ttc_regs.vh"
// One timer: prescaler, counter, two compares, NCAP captures
module ttc_timer #(
    parameter NCAP = 2,
    parameter W = 16
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire run_stop_bit_in,
    input wire [2:0] count_clock_select_in,
    input wire counter_clear_bit_in,
    input wire clear_on_match_in,
    input wire [1:0] out_sel_a_in,
    input wire [1:0] out_sel_b_in,
    input wire [W-1:0] compare_reg_a_in,
    input wire [W-1:0] compare_reg_b_in,
    input wire [2*NCAP-1:0] cap_edge_sel_in,
    input wire [NCAP-1:0] cap_pin_in,
    input wire ext_tick_in,
    input wire [NCAP+2:0] irq_en_in,
    input wire [NCAP+2:0] irq_clr_in,
    output reg [W-1:0] count_out,
    output wire [NCAP*W-1:0] capture_out,
    output reg compare_out_a,
    output reg compare_out_b,
    output reg [NCAP+2:0] irq_status_out,
    output wire irq_out
);
    reg [6:0] pre_r;
    reg [2:0] sel_r;
    wire [NCAP-1:0] cap_ev;
    reg tick;
    // Low prescaler bits that must all be set for a divided tick
    wire [6:0] div_mask = `TTC_PRE_ALL >> (`TTC_SEL_DIV_MAX - sel_r);
    wire match_a = (count_out == compare_reg_a_in);
    wire match_b = (count_out == compare_reg_b_in);
    wire ovf = tick && run_stop_bit_in && (count_out == `TTC_CNT_MAX);

    // Tick select: divided system clock or external tick
    always @* begin
        if (sel_r == `TTC_SEL_EXT)
            tick = ext_tick_in;
        else
            tick = ((pre_r & div_mask) == div_mask);
    end

    // Prescaler runs freely; clock select latches only while stopped
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_r <= `TTC_PRE_RST;
            sel_r <= `TTC_SEL_RST;
        end else begin
            pre_r <= pre_r + 7'h01;
            if (!run_stop_bit_in)
                sel_r <= count_clock_select_in;
        end
    end

    // Counter: clear, compare clear, count
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            count_out <= `TTC_CNT_RST;
        else if (counter_clear_bit_in)
            count_out <= `TTC_CNT_RST;
        else if (run_stop_bit_in && tick) begin
            if (clear_on_match_in && match_b)
                count_out <= `TTC_CNT_RST;
            else
                count_out <= count_out + 16'h0001;
        end
    end

    // Compare outputs act on the count tick while matching
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_out_a <= 1'b0;
            compare_out_b <= 1'b0;
        end else if (run_stop_bit_in && tick) begin
            if (match_a) begin
                case (out_sel_a_in)
                    `TTC_OUT_LOW: compare_out_a <= 1'b0;
                    `TTC_OUT_HIGH: compare_out_a <= 1'b1;
                    `TTC_OUT_TGL: compare_out_a <= ~compare_out_a;
                    default: compare_out_a <= compare_out_a;
                endcase
            end
            if (match_b) begin
                case (out_sel_b_in)
                    `TTC_OUT_LOW: compare_out_b <= 1'b0;
                    `TTC_OUT_HIGH: compare_out_b <= 1'b1;
                    `TTC_OUT_TGL: compare_out_b <= ~compare_out_b;
                    default: compare_out_b <= compare_out_b;
                endcase
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCAP; g = g + 1) begin : cap_g
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg [W-1:0] cap_r;
            wire [1:0] edge_sel = cap_edge_sel_in[2*g +: 2];
            // Selected edge between the last two stages; code 00 ignores
            assign cap_ev[g] =
                ((edge_sel == `TTC_EDGE_RISE) && s2_r && !s3_r) ||
                ((edge_sel == `TTC_EDGE_FALL) && !s2_r && s3_r) ||
                ((edge_sel == `TTC_EDGE_BOTH) && (s2_r != s3_r));
            assign capture_out[g*W +: W] = cap_r;
            // Two-stage synchroniser, edge stage, then capture register
            always @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    cap_r <= `TTC_CNT_RST;
                end else begin
                    s1_r <= cap_pin_in[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (cap_ev[g])
                        cap_r <= count_out;
                end
            end
        end
    endgenerate

    // Sticky flags: {captures, ovf, cmp_b, cmp_a}; set wins over clear
    wire [NCAP+2:0] ev = {cap_ev, ovf, run_stop_bit_in & tick & match_b,
        run_stop_bit_in & tick & match_a};
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            irq_status_out <= {(NCAP+3){1'b0}};
        else
            irq_status_out <= ev | (irq_status_out & ~irq_clr_in);
    end

    assign irq_out = |(irq_status_out & irq_en_in);
endmodule

// >>> src/ttc_top.v
`timescale 1ns/1ps
`include "ttc_regs.vh"
// Behaviour
// - Three 16-bit up counters; timer 0 five captures, others two.
// - Wrap from FFFF to 0000 flags an overflow event.
// - Each timer has own prescaler; external clock is shared.
// - Each capture input has selectable edge and optional interrupt.
// - Compare match drives its output pin to programmed level.
// - One interrupt per timer while any enabled flag is pending.
// - Clock selection only updates while the counter is stopped.
// - External clock rise increments count on third system edge.
// - Match when counter equals compare register value.
// - Compare B match with clear_on_match clears on next tick.
// - Compare A shows on output A, compare B on output B.
// - Counting and compare advance only on count clock ticks.
// - Capture inputs sampled each clock; pulses at least two clocks.
// - Two-stage synchroniser, then selected edge stores the count.
// - Select codes 0-6 divide by 2 to 128; 7 is external.
// - Output select: keep, low, high, toggle.
// - Counter clear strobe zeroes the counter; reads as zero.
// - Capture edge: off, rising, falling, both.
module ttc_top #(
    parameter W = 16
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire ext_count_clock_in,
    input wire [2:0] run_stop_bit_in,
    input wire [8:0] count_clock_select_in,
    input wire [2:0] counter_clear_bit_in,
    input wire [2:0] clear_on_match_in,
    input wire [5:0] out_sel_a_in,
    input wire [5:0] out_sel_b_in,
    input wire [3*W-1:0] compare_reg_a_in,
    input wire [3*W-1:0] compare_reg_b_in,
    input wire [17:0] cap_edge_sel_in,
    input wire [8:0] capture_input_in,
    input wire [7:0] t0_irq_en_in,
    input wire [7:0] t0_irq_clr_in,
    input wire [4:0] t1_irq_en_in,
    input wire [4:0] t1_irq_clr_in,
    input wire [4:0] t2_irq_en_in,
    input wire [4:0] t2_irq_clr_in,
    output wire [3*W-1:0] count_out,
    output wire [9*W-1:0] capture_out,
    output wire [2:0] compare_out_a,
    output wire [2:0] compare_out_b,
    output wire [7:0] t0_irq_status_out,
    output wire [4:0] t1_irq_status_out,
    output wire [4:0] t2_irq_status_out,
    output wire [2:0] irq_out
);
    // External clock: two-stage sync plus edge stage; tick lands third edge
    reg ext_s1_r;
    reg ext_s2_r;
    reg ext_s3_r;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_count_clock_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end
    wire ext_tick = ext_s2_r & ~ext_s3_r;

    // Timer 0 with five captures
    ttc_timer #(.NCAP(5), .W(W)) u_t0 (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .run_stop_bit_in(run_stop_bit_in[0]),
        .count_clock_select_in(count_clock_select_in[2:0]),
        .counter_clear_bit_in(counter_clear_bit_in[0]),
        .clear_on_match_in(clear_on_match_in[0]),
        .out_sel_a_in(out_sel_a_in[1:0]),
        .out_sel_b_in(out_sel_b_in[1:0]),
        .compare_reg_a_in(compare_reg_a_in[W-1:0]),
        .compare_reg_b_in(compare_reg_b_in[W-1:0]),
        .cap_edge_sel_in(cap_edge_sel_in[9:0]),
        .cap_pin_in(capture_input_in[4:0]),
        .ext_tick_in(ext_tick),
        .irq_en_in(t0_irq_en_in),
        .irq_clr_in(t0_irq_clr_in),
        .count_out(count_out[W-1:0]),
        .capture_out(capture_out[5*W-1:0]),
        .compare_out_a(compare_out_a[0]),
        .compare_out_b(compare_out_b[0]),
        .irq_status_out(t0_irq_status_out),
        .irq_out(irq_out[0])
    );

    // Timer 1 with two captures
    ttc_timer #(.NCAP(2), .W(W)) u_t1 (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .run_stop_bit_in(run_stop_bit_in[1]),
        .count_clock_select_in(count_clock_select_in[5:3]),
        .counter_clear_bit_in(counter_clear_bit_in[1]),
        .clear_on_match_in(clear_on_match_in[1]),
        .out_sel_a_in(out_sel_a_in[3:2]),
        .out_sel_b_in(out_sel_b_in[3:2]),
        .compare_reg_a_in(compare_reg_a_in[2*W-1:W]),
        .compare_reg_b_in(compare_reg_b_in[2*W-1:W]),
        .cap_edge_sel_in(cap_edge_sel_in[13:10]),
        .cap_pin_in(capture_input_in[6:5]),
        .ext_tick_in(ext_tick),
        .irq_en_in(t1_irq_en_in),
        .irq_clr_in(t1_irq_clr_in),
        .count_out(count_out[2*W-1:W]),
        .capture_out(capture_out[7*W-1:5*W]),
        .compare_out_a(compare_out_a[1]),
        .compare_out_b(compare_out_b[1]),
        .irq_status_out(t1_irq_status_out),
        .irq_out(irq_out[1])
    );

    // Timer 2 with two captures
    ttc_timer #(.NCAP(2), .W(W)) u_t2 (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .run_stop_bit_in(run_stop_bit_in[2]),
        .count_clock_select_in(count_clock_select_in[8:6]),
        .counter_clear_bit_in(counter_clear_bit_in[2]),
        .clear_on_match_in(clear_on_match_in[2]),
        .out_sel_a_in(out_sel_a_in[5:4]),
        .out_sel_b_in(out_sel_b_in[5:4]),
        .compare_reg_a_in(compare_reg_a_in[3*W-1:2*W]),
        .compare_reg_b_in(compare_reg_b_in[3*W-1:2*W]),
        .cap_edge_sel_in(cap_edge_sel_in[17:14]),
        .cap_pin_in(capture_input_in[8:7]),
        .ext_tick_in(ext_tick),
        .irq_en_in(t2_irq_en_in),
        .irq_clr_in(t2_irq_clr_in),
        .count_out(count_out[3*W-1:2*W]),
        .capture_out(capture_out[9*W-1:7*W]),
        .compare_out_a(compare_out_a[2]),
        .compare_out_b(compare_out_b[2]),
        .irq_status_out(t2_irq_status_out),
        .irq_out(irq_out[2])
    );
endmodule

// >>> dv/ttc_top_checker.sv
`timescale 1ns/1ps
// Watches timer 0 at the top level ports
module ttc_chk #(
    parameter W = 16
) (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire [2:0] run_stop_bit_in,
    input wire [2:0] counter_clear_bit_in,
    input wire [2:0] clear_on_match_in,
    input wire [5:0] out_sel_a_in,
    input wire [3*W-1:0] compare_reg_a_in,
    input wire [3*W-1:0] compare_reg_b_in,
    input wire [7:0] t0_irq_en_in,
    input wire [7:0] t0_irq_clr_in,
    input wire [3*W-1:0] count_out,
    input wire [9*W-1:0] capture_out,
    input wire [2:0] compare_out_a,
    input wire [7:0] t0_irq_status_out,
    input wire [2:0] irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Timer 0 count and its running match conditions
    wire [W-1:0] c0 = count_out[W-1:0];
    wire ma = run_stop_bit_in[0] && c0 == compare_reg_a_in[W-1:0];
    wire mb = run_stop_bit_in[0] && clear_on_match_in[0]
        && c0 == compare_reg_b_in[W-1:0];
    AST_HOLD:
        assert property (!run_stop_bit_in[0] && !counter_clear_bit_in[0]
        |=> $stable(c0)) else $error("count moved while stopped");
    AST_CLR:
        assert property (counter_clear_bit_in[0] |=> c0 == 16'h0000)
        else $error("clear strobe ignored");
    AST_STEP:
        assert property ($changed(c0) && !$past(counter_clear_bit_in[0])
        && !$past(mb) |-> c0 == $past(c0) + 16'h0001) else $error("bad step");
    AST_MCLR:
        assert property ($past(mb) && $changed(c0) |-> c0 == 16'h0000)
        else $error("no clear on compare b");
    AST_OUTA:
        assert property ($rose(compare_out_a[0]) |-> $past(ma)
        && $past(out_sel_a_in[1]) && t0_irq_status_out[0])
        else $error("output a rose without match");
    AST_IRQ:
        assert property (irq_out[0] == |(t0_irq_status_out & t0_irq_en_in))
        else $error("interrupt line wrong");
    AST_CAPV:
        assert property ($changed(capture_out[W-1:0])
        |-> capture_out[W-1:0] == $past(c0)) else $error("bad capture");
    AST_STICKY:
        assert property ($fell(t0_irq_status_out[0])
        |-> $past(t0_irq_clr_in[0])) else $error("flag dropped by itself");
    AST_OVF:
        assert property ($rose(t0_irq_status_out[2])
        |-> $past(c0) == 16'hFFFF) else $error("overflow without wrap");
    // Main scenarios
    cover property ($rose(compare_out_a[0]));
    cover property ($changed(capture_out[W-1:0]));
    cover property ($past(mb) && c0 == 16'h0000);
endmodule
bind ttc_top ttc_chk #(.W(W)) ttc_chk_i (.core_clk_in, .rst_n_in,
    .run_stop_bit_in, .counter_clear_bit_in, .clear_on_match_in,
    .out_sel_a_in, .compare_reg_a_in, .compare_reg_b_in, .t0_irq_en_in,
    .t0_irq_clr_in, .count_out, .capture_out, .compare_out_a,
    .t0_irq_status_out, .irq_out);

// >>> dv/ttc_pins.sv
`timescale 1ns/1ps
// Far side: shared external count clock and capture pins
module ttc_pins (
    input wire core_clk_in,
    output reg ext_count_clock_out,
    output reg [8:0] cap_pins_out
);
    initial begin
        ext_count_clock_out = 1'b0;
        cap_pins_out = 9'h000;
    end
    // New level lands just after a falling edge
    task ext_set(input logic lvl);
        begin
            @(negedge core_clk_in);
            ext_count_clock_out = lvl;
        end
    endtask
    // Capture level held two clocks so the sampler sees it
    task cap_set(input integer k, input logic lvl);
        begin
            @(negedge core_clk_in);
            cap_pins_out[k] = lvl;
            repeat (2) @(negedge core_clk_in);
        end
    endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the three timers
module tb;
    localparam [5:0] out_codes = 6'h0d;
    localparam [2:0] out_exp = 3'h6;
    logic clk, rst_n, ext;
    logic [2:0] run, clr, com, oa, ob, irq;
    logic [8:0] sel, cpin;
    logic [5:0] osa, osb;
    logic [47:0] cmpa, cmpb, cnt;
    logic [17:0] edg;
    logic [7:0] en0, cl0, st0;
    logic [4:0] en12, st1;
    logic [143:0] cap;
    integer fails, num_checks;
    ttc_pins ttc_pins_i (.core_clk_in(clk), .ext_count_clock_out(ext),
        .cap_pins_out(cpin));
    ttc_top ttc_top_i (.core_clk_in(clk), .rst_n_in(rst_n),
        .ext_count_clock_in(ext), .run_stop_bit_in(run),
        .count_clock_select_in(sel), .counter_clear_bit_in(clr),
        .clear_on_match_in(com), .out_sel_a_in(osa), .out_sel_b_in(osb),
        .compare_reg_a_in(cmpa), .compare_reg_b_in(cmpb),
        .cap_edge_sel_in(edg), .capture_input_in(cpin), .t0_irq_en_in(en0),
        .t0_irq_clr_in(cl0), .t1_irq_en_in(en12), .t1_irq_clr_in(5'h00),
        .t2_irq_en_in(en12), .t2_irq_clr_in(5'h00), .count_out(cnt),
        .capture_out(cap), .compare_out_a(oa), .compare_out_b(ob),
        .t0_irq_status_out(st0), .t1_irq_status_out(st1),
        .t2_irq_status_out(), .irq_out(irq));
    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        begin
            num_checks++;
            if (got !== exp) begin
                fails++;
                $display("wrong value at %0t: %s", $time, m);
            end
        end
    endtask
    task clr_flags;
        begin
            @(negedge clk);
            cl0 = 8'hff;
            @(negedge clk);
            cl0 = 8'h00;
        end
    endtask
    // Every divider code, then a select change while running
    task t_prescale;
        integer s;
        begin
            for (s = 0; s < 8; s++) begin
                @(negedge clk);
                // Last pass keeps running so its select write is ignored
                run[0] = (s == 7);
                sel[2:0] = (s < 7) ? s[2:0] : 3'h0;
                clr[0] = 1'b1;
                @(negedge clk);
                run[0] = 1'b1;
                clr[0] = 1'b0;
                repeat (4 << ((s < 7) ? s + 1 : 7)) @(negedge clk);
                chk(cnt[15:0], 16'h0004, "prescale");
            end
            run[0] = 1'b0;
            repeat (20) @(negedge clk);
            chk(cnt[15:0], 16'h0004, "stopped");
            $display("test prescale done");
        end
    endtask
    // External clock shared by timers 1 and 2
    task t_ext;
        integer i;
        begin
            @(negedge clk);
            sel[8:3] = 6'h3f;
            clr[2:1] = 2'h3;
            @(negedge clk);
            run[2:1] = 2'h3;
            clr[2:1] = 2'h0;
            for (i = 0; i < 3; i++) begin
                ttc_pins_i.ext_set(1'b1);
                @(posedge clk);
                @(posedge clk);
                @(negedge clk);
                chk(cnt[31:16], i[15:0], "ext early");
                @(negedge clk);
                chk(cnt[31:16], i[15:0] + 16'h0001, "ext third");
                chk(cnt[47:32], i[15:0] + 16'h0001, "ext shared");
                ttc_pins_i.ext_set(1'b0);
                @(negedge clk);
            end
            // Both compares sit at zero, so flags a and b are pending
            chk(st1, 16'h0003, "ext flags");
            chk(irq[2:1], 16'h0003, "ext irq");
            en12 = 5'h00;
            @(negedge clk);
            chk(irq[2:1], 16'h0000, "ext irq masked");
            $display("test ext done");
        end
    endtask
    // Compare actions, clear on compare b, interrupt line
    task t_compare;
        integer i;
        logic [15:0] m;
        begin
            @(negedge clk);
            clr[0] = 1'b1;
            com[0] = 1'b1;
            cmpa[15:0] = 16'h0003;
            cmpb[15:0] = 16'h0005;
            osa[1:0] = 2'h2;
            osb[1:0] = 2'h2;
            en0 = 8'hff;
            @(negedge clk);
            run[0] = 1'b1;
            clr[0] = 1'b0;
            m = 16'h0000;
            repeat (40) begin
                @(negedge clk);
                if (cnt[15:0] > m)
                    m = cnt[15:0];
            end
            chk(m, 16'h0005, "clear on match");
            chk(oa[0], 16'h0001, "out a");
            chk(ob[0], 16'h0001, "out b");
            chk(irq[0], 16'h0001, "irq set");
            for (i = 0; i < 3; i++) begin
                osa[1:0] = out_codes[2*i+:2];
                repeat (12) @(negedge clk);
                chk(oa[0], out_exp[i], "out code");
            end
            en0 = 8'h00;
            @(negedge clk);
            chk(irq[0], 16'h0000, "irq masked");
            en0 = 8'hff;
            run[0] = 1'b0;
            clr_flags;
            chk(st0, 16'h0000, "flags cleared");
            $display("test compare done");
        end
    endtask
    // Every edge code on two capture inputs, counter held at 4
    task t_capture;
        integer k, c;
        begin
            run[0] = 1'b1;
            for (c = 0; c < 30 && cnt[15:0] !== 16'h0004; c++) @(negedge clk);
            run[0] = 1'b0;
            chk(cnt[15:0], 16'h0004, "count parked");
            for (k = 0; k < 5; k += 4) begin
                for (c = 0; c < 4; c++) begin
                    edg[2*k+:2] = c[1:0];
                    clr_flags;
                    ttc_pins_i.cap_set(k, 1'b1);
                    repeat (3) @(negedge clk);
                    chk(st0[3+k], c[0], "rise");
                    clr_flags;
                    ttc_pins_i.cap_set(k, 1'b0);
                    repeat (3) @(negedge clk);
                    chk(st0[3+k], c[1], "fall");
                end
                chk(cap[16*k+:16], 16'h0004, "captured");
            end
            $display("test capture done");
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (10000) @(posedge clk);
        fails++;
        print_verdict;
    end
    initial begin
        {run, clr, com, sel, osa, osb, cmpa, cmpb, edg, en0, cl0} = '0;
        en12 = 5'h01;
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_prescale;
        t_ext;
        t_compare;
        t_capture;
        print_verdict;
    end
endmodule
